// [rtl/wdtrf_consts.vh]
/*
 watchdog and reset-cause constants: register offsets, field positions,
 reset values and timing counts. included by bare name.
*/
`ifndef WDTRF_CONSTS_VH
`define WDTRF_CONSTS_VH
`define WDTRF_ADDR_CTRL 12'h0084
`define WDTRF_ADDR_CAUSE 12'h0088
`define WDTRF_IDX_CTRL 8'h21
`define WDTRF_IDX_CAUSE 8'h22
`define WDTRF_CTRL_RST 8'h00
`define WDTRF_BIT_CE 4
`define WDTRF_BIT_EN 3
`define WDTRF_BIT_SCAN 4
`define WDTRF_BIT_TMO 3
`define WDTRF_BIT_BOR 2
`define WDTRF_BIT_PIN 1
`define WDTRF_BIT_POR 0
`define WDTRF_CE_CYCLES 3'h4
`define WDTRF_BASE_LOG2 14
`define WDTRF_OSC_MHZ 1
`define WDTRF_CNT_W 21
`endif

// [rtl/wdtrf_sync.v]
/*
 two-flop level synchroniser.
 assumes d_in is a level that stays for several destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module wdtrf_sync (
   input wire clk,
   input wire d_in,
   output wire q_out
);
   reg s1_reg;
   reg s2_reg;
   always @(posedge clk) begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
   end
   assign q_out = s2_reg;
endmodule // wdtrf_sync
`default_nettype wire

// [rtl/wdtrf_count.v]
/*
 watchdog counter in the oscillator domain.
 assumes restart and enable arrive already synchronised; tmo_tgl toggles once per time-out.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtrf_consts.vh"
module wdtrf_count #(
   parameter integer BASE_LOG2 = `WDTRF_BASE_LOG2,
   parameter integer CNT_W = `WDTRF_CNT_W
) (
   input wire osc_clk,
   input wire enable,
   input wire restart,
   input wire [2:0] sel,
   output reg tmo_tgl
);
   reg [CNT_W-1:0] cnt_reg;
   wire [CNT_W-1:0] limit;
   assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (BASE_LOG2 + sel)) - {{(CNT_W-1){1'b0}}, 1'b1};
   initial tmo_tgl = 1'b0;
   initial cnt_reg = {CNT_W{1'b0}};
   always @(posedge osc_clk) begin
      if (!enable || restart) begin
         cnt_reg <= {CNT_W{1'b0}};
      end else if (cnt_reg >= limit) begin
         cnt_reg <= {CNT_W{1'b0}};
         tmo_tgl <= ~tmo_tgl;
      end else begin
         cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule // wdtrf_count
`default_nettype wire

// [rtl/wdtrf_top.v]
/*
 watchdog with safety levels and reset-cause flags, APB slave.
 assumes fuses static, reset cause pulses synchronous to CLK, WDT_OSC free running.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtrf_consts.vh"
module wdtrf_top #(
   parameter integer BASE_LOG2 = `WDTRF_BASE_LOG2
) (
   input wire CLK,
   input wire SYS_RST,
   input wire WDT_OSC,
   input wire LEGACY_COMPAT_FUSE,
   input wire ALWAYS_ON_FUSE,
   input wire RESTART_INSN,
   input wire RST_POWERON,
   input wire RST_PIN,
   input wire RST_BROWNOUT,
   input wire RST_SCAN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [3:0] PSTRB,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   output reg WDT_RESET,
   output reg [1:0] SAFETY_LEVEL
);
   // fuses: 1 = programmed
   wire [1:0] level;
   assign level = ALWAYS_ON_FUSE ? 2'd2 : (LEGACY_COMPAT_FUSE ? 2'd0 : 2'd1);
   wire lvl2;
   assign lvl2 = (level == 2'd2);

   reg en_reg;
   reg [2:0] sel_reg;
   reg ce_reg;
   reg [2:0] ce_cnt_reg;
   reg [4:0] flags_reg;
   reg init_reg;

   // apb decode
   wire acc;
   assign acc = PSEL && PENABLE && PREADY;
   wire hit_ctrl;
   assign hit_ctrl = (PADDR == `WDTRF_ADDR_CTRL);
   wire hit_cause;
   assign hit_cause = (PADDR == `WDTRF_ADDR_CAUSE);
   wire wr_ctrl;
   assign wr_ctrl = acc && PWRITE && hit_ctrl && PSTRB[0];
   wire wr_cause;
   assign wr_cause = acc && PWRITE && hit_cause && PSTRB[0];
   wire [7:0] wd;
   assign wd = PWDATA[7:0];
   wire w_ce;
   assign w_ce = wd[`WDTRF_BIT_CE];
   wire w_en;
   assign w_en = wd[`WDTRF_BIT_EN];

   // time-out event back into CLK domain
   wire tmo_tgl;
   wire tmo_sync;
   reg tmo_prev_reg;
   wire tmo_evt;
   assign tmo_evt = tmo_sync ^ tmo_prev_reg;
   wire any_rst;
   assign any_rst = RST_POWERON | RST_PIN | RST_BROWNOUT | RST_SCAN | tmo_evt;

   // control register next state
   reg en_next;
   reg [2:0] sel_next;
   reg ce_next;
   reg [2:0] ce_cnt_next;
   always @* begin
      en_next = en_reg;
      sel_next = sel_reg;
      ce_next = ce_reg;
      ce_cnt_next = ce_cnt_reg;
      if (ce_reg) begin
         if (ce_cnt_reg == `WDTRF_CE_CYCLES - 3'h1) begin
            ce_next = 1'b0;
            ce_cnt_next = 3'h0;
         end else begin
            ce_cnt_next = ce_cnt_reg + 3'h1;
         end
      end
      if (wr_ctrl) begin
         if (w_en) begin
            en_next = 1'b1;
         end else if (ce_reg && !lvl2) begin
            en_next = 1'b0;
         end
         if (level == 2'd0 || ce_reg) begin
            sel_next = wd[2:0];
         end
         if (w_ce && w_en) begin
            ce_next = 1'b1;
            ce_cnt_next = 3'h0;
         end else if (!w_ce) begin
            ce_next = 1'b0;
            ce_cnt_next = 3'h0;
         end
      end
      if (lvl2) begin
         en_next = 1'b1;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         en_reg <= 1'b0;
         sel_reg <= 3'h0;
         ce_reg <= 1'b0;
         ce_cnt_reg <= 3'h0;
         init_reg <= 1'b1;
      end else if (init_reg || any_rst) begin
         en_reg <= lvl2;
         sel_reg <= 3'h0;
         ce_reg <= 1'b0;
         ce_cnt_reg <= 3'h0;
         init_reg <= 1'b0;
      end else begin
         en_reg <= en_next;
         sel_reg <= sel_next;
         ce_reg <= ce_next;
         ce_cnt_reg <= ce_cnt_next;
      end
   end

   // restart crosses by four-phase handshake
   // a short pulse would be lost between slow oscillator edges
   wire rs_evt;
   assign rs_evt = RESTART_INSN || any_rst;
   wire rs_ack_sync;
   reg rs_req_reg;
   reg rs_pend_reg;
   reg rs_req_next;
   reg rs_pend_next;
   always @* begin
      rs_req_next = rs_req_reg;
      rs_pend_next = rs_pend_reg || rs_evt;
      if (rs_req_reg) begin
         if (rs_ack_sync) begin
            rs_req_next = 1'b0;
         end
      end else if (!rs_ack_sync && rs_pend_next) begin
         rs_req_next = 1'b1;
         rs_pend_next = 1'b0;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         rs_req_reg <= 1'b0;
         rs_pend_reg <= 1'b1;
      end else begin
         rs_req_reg <= rs_req_next;
         rs_pend_reg <= rs_pend_next;
      end
   end

   // time-out select crosses as a held word with its own handshake
   wire sel_ack_sync;
   reg [2:0] sel_xfer_reg;
   reg sel_req_reg;
   reg sel_dirty_reg;
   reg [2:0] sel_xfer_next;
   reg sel_req_next;
   reg sel_dirty_next;
   always @* begin
      sel_xfer_next = sel_xfer_reg;
      sel_req_next = sel_req_reg;
      sel_dirty_next = sel_dirty_reg;
      if (sel_req_reg) begin
         if (sel_ack_sync) begin
            sel_req_next = 1'b0;
         end
      end else if (!sel_ack_sync && (sel_dirty_reg || sel_reg != sel_xfer_reg)) begin
         sel_xfer_next = sel_reg;
         sel_req_next = 1'b1;
         sel_dirty_next = 1'b0;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         sel_xfer_reg <= 3'h0;
         sel_req_reg <= 1'b0;
         sel_dirty_reg <= 1'b1;
      end else begin
         sel_xfer_reg <= sel_xfer_next;
         sel_req_reg <= sel_req_next;
         sel_dirty_reg <= sel_dirty_next;
      end
   end

   wire en_sync;
   wire rs_sync;
   wire sel_req_sync;
   reg [2:0] sel_osc_reg;
   wdtrf_sync u_sync_en (.clk(WDT_OSC), .d_in(en_reg), .q_out(en_sync));
   wdtrf_sync u_sync_rs (.clk(WDT_OSC), .d_in(rs_req_reg), .q_out(rs_sync));
   wdtrf_sync u_sync_rs_ack (.clk(CLK), .d_in(rs_sync), .q_out(rs_ack_sync));
   wdtrf_sync u_sync_sel (.clk(WDT_OSC), .d_in(sel_req_reg), .q_out(sel_req_sync));
   wdtrf_sync u_sync_sel_ack (.clk(CLK), .d_in(sel_req_sync), .q_out(sel_ack_sync));

   // held word is stable while the request is seen high
   initial sel_osc_reg = 3'h0;
   always @(posedge WDT_OSC) begin
      if (sel_req_sync) begin
         sel_osc_reg <= sel_xfer_reg;
      end
   end

   wdtrf_count #(.BASE_LOG2(BASE_LOG2), .CNT_W(`WDTRF_CNT_W)) u_count (
      .osc_clk(WDT_OSC),
      .enable(en_sync),
      .restart(rs_sync),
      .sel(sel_osc_reg),
      .tmo_tgl(tmo_tgl)
   );
   wdtrf_sync u_sync_tmo (.clk(CLK), .d_in(tmo_tgl), .q_out(tmo_sync));

   always @(posedge CLK) begin
      if (SYS_RST) begin
         tmo_prev_reg <= 1'b0;
         WDT_RESET <= 1'b0;
      end else begin
         tmo_prev_reg <= tmo_sync;
         WDT_RESET <= tmo_evt && en_reg;
      end
   end

   // reset cause flags; set wins over software clear
   reg [4:0] flags_next;
   always @* begin
      flags_next = flags_reg;
      if (wr_cause) begin
         flags_next = flags_reg & wd[4:0];
      end
      if (RST_BROWNOUT) begin
         flags_next[`WDTRF_BIT_SCAN] = 1'b0;
      end
      if (RST_POWERON) begin
         flags_next[`WDTRF_BIT_TMO] = 1'b0;
         flags_next[`WDTRF_BIT_BOR] = 1'b0;
         flags_next[`WDTRF_BIT_PIN] = 1'b0;
         flags_next[`WDTRF_BIT_POR] = 1'b1;
      end
      if (RST_SCAN) begin
         flags_next[`WDTRF_BIT_SCAN] = 1'b1;
      end
      if (WDT_RESET) begin
         flags_next[`WDTRF_BIT_TMO] = 1'b1;
      end
      if (RST_BROWNOUT) begin
         flags_next[`WDTRF_BIT_BOR] = 1'b1;
      end
      if (RST_PIN) begin
         flags_next[`WDTRF_BIT_PIN] = 1'b1;
      end
      if (LEGACY_COMPAT_FUSE) begin
         flags_next[4:2] = 3'h0;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         flags_reg <= 5'h00;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // apb read and answer, one wait state
   wire [7:0] ctrl_rd;
   assign ctrl_rd = {3'h0, ce_reg, en_reg | lvl2, sel_reg};
   always @(posedge CLK) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
         SAFETY_LEVEL <= 2'h0;
      end else begin
         SAFETY_LEVEL <= level;
         PREADY <= PSEL && PENABLE && !PREADY;
         if (PSEL && PENABLE && !PREADY) begin
            PSLVERR <= !(hit_ctrl || hit_cause);
            if (hit_ctrl) begin
               PRDATA <= {24'h00_0000, ctrl_rd};
            end else if (hit_cause) begin
               PRDATA <= {27'h000_0000, flags_reg};
            end else begin
               PRDATA <= 32'h0000_0000;
            end
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end
endmodule // wdtrf_top
`default_nettype wire

// [test/wdtrf_chk.sv]
/* assertions on the ports of wdtrf_top.
   assumes it is bound to every wdtrf_top instance. */
`timescale 1ns/1ps
`default_nettype none
`include "wdtrf_consts.vh"
module wdtrf_chk (
   input wire CLK,
   input wire SYS_RST,
   input wire LEGACY_COMPAT_FUSE,
   input wire ALWAYS_ON_FUSE,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire WDT_RESET,
   input wire [1:0] SAFETY_LEVEL
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire rd_ctl = PREADY && !PWRITE && PADDR == `WDTRF_ADDR_CTRL;
   wire rd_cau = PREADY && !PWRITE && PADDR == `WDTRF_ADDR_CAUSE;
   wire mapped = PADDR == `WDTRF_ADDR_CTRL || PADDR == `WDTRF_ADDR_CAUSE;
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_access;
      PSEL && PENABLE;
   endsequence
   AST_WALK: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
      else $error("pready not on second access cycle");
   AST_ONE: assert property (PREADY |=> !PREADY)
      else $error("pready longer than one cycle");
   AST_ERR: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_RSV: assert property (rd_ctl |-> PRDATA[31:5] == 27'h000_0000)
      else $error("control upper bits not zero");
   AST_L2EN: assert property (rd_ctl && SAFETY_LEVEL == 2'h2 |-> PRDATA[3])
      else $error("enable reads zero in level 2");
   AST_LVL: assert property (!$past(SYS_RST) |->
      SAFETY_LEVEL == (ALWAYS_ON_FUSE ? 2'h2 : {1'b0, !LEGACY_COMPAT_FUSE}))
      else $error("safety level does not match fuses");
   AST_PLS: assert property (WDT_RESET |=> !WDT_RESET)
      else $error("timeout reset longer than one cycle");
   AST_LEG: assert property (rd_cau && LEGACY_COMPAT_FUSE |-> PRDATA[4:2] == 3'h0)
      else $error("legacy mode shows extra flags");
endmodule // wdtrf_chk
bind wdtrf_top wdtrf_chk wdtrf_chk_i (.*);
`default_nettype wire

// [test/tb.sv]
/* self-checking bench for wdtrf_top over apb.
   assumes wdtrf_chk is bound and the oscillator runs at clk/8. */
`timescale 1ns/1ps
`default_nettype none
`include "wdtrf_consts.vh"
module tb;
   localparam logic [11:0] AC = `WDTRF_ADDR_CTRL;
   localparam logic [11:0] AF = `WDTRF_ADDR_CAUSE;
   localparam logic [3:0] SP [5] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h4};
   localparam logic [7:0] EX [5] = '{8'h02, 8'h06, 8'h16, 8'h11, 8'h05};
   logic clk = 0, rst = 1, osc = 0, lf = 0, af = 0, rs = 0, psel = 0, pen = 0, pwr = 0, e;
   logic [3:0] src = 4'h0;
   logic [3:0] stb = 4'hF;
   logic [11:0] pa = 12'h000;
   logic [7:0] pw = 8'h00;
   logic [31:0] prd, q;
   logic rdy, err, wrst;
   logic [1:0] lvl;
   int error_cnt = 0, num_checks = 0, c;
   wdtrf_top #(.BASE_LOG2(4)) wdtrf_top_i (.CLK(clk), .SYS_RST(rst), .WDT_OSC(osc),
      .LEGACY_COMPAT_FUSE(lf), .ALWAYS_ON_FUSE(af), .RESTART_INSN(rs), .RST_POWERON(src[0]),
      .RST_PIN(src[1]), .RST_BROWNOUT(src[2]), .RST_SCAN(src[3]), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(pa), .PWDATA({24'h00_0000, pw}), .PSTRB(stb), .PRDATA(prd),
      .PREADY(rdy), .PSLVERR(err), .WDT_RESET(wrst), .SAFETY_LEVEL(lvl));
   always #2 clk = ~clk;
   always #16 osc = ~osc;
   task final_report;
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task ck(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("unexpected at %0t got %h expected %h", $time, g, x);
      end
   endtask
   task gap(input int n);
      psel <= 0;
      pen <= 0;
      repeat (n) @(posedge clk);
   endtask
   // leaves the request up so a following call can start at once
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      pa <= a;
      pw <= d;
      @(posedge clk) pen <= 1;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (rdy !== 1'b1 && c < 20);
      q = prd;
      e = err;
      if (c >= 20) ck(32'h0000_0000, 32'h0000_0001);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      ck(q, {24'h00_0000, x});
   endtask
   task pls(input logic [3:0] s);
      gap(0);
      src <= s;
      @(posedge clk) src <= 4'h0;
      repeat (4) @(posedge clk);
   endtask
   task kick;
      gap(0);
      rs <= 1;
      @(posedge clk) rs <= 0;
   endtask
   task wt(input int lim);
      gap(0);
      c = 0;
      while (wrst !== 1'b1 && c < lim) begin
         @(posedge clk);
         c++;
      end
   endtask
   task rst_to(input logic l, input logic a, input logic [1:0] x);
      gap(0);
      lf <= l;
      af <= a;
      rst <= 1;
      repeat (12) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      ck(lvl, x);
      rd(AC, x == 2'h2 ? 8'h08 : 8'h00);
   endtask
   task s_lvl;
      for (int i = 0; i < 4; i++) rst_to(i[1], i[0], i[0] ? 2'h2 : {1'b0, !i[1]});
   endtask
   task s_l1;
      rst_to(1'b0, 1'b0, 2'h1);
      wr(AC, 8'h0E);
      rd(AC, 8'h08);
      wr(AC, 8'h18);
      wr(AC, 8'h05);
      rd(AC, 8'h05);
      wr(AC, 8'hE8);
      rd(AC, 8'h0D);
      wr(AC, 8'h1D);
      gap(5);
      wr(AC, 8'h00);
      rd(AC, 8'h0D);
   endtask
   task s_tmo;
      wr(AF, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(AC, 8'h18);
         wr(AC, {7'h04, i[0]});
         kick();
         wt(1000);
         ck(c >= (120 << i) && c < (192 << i), 32'h0000_0001);
         rd(AF, 8'h08);
         rd(AC, 8'h00);
      end
      wr(AC, 8'h08);
      repeat (8) begin
         kick();
         wt(60);
         ck(c, 60);
      end
   endtask
   task s_flg;
      rst_to(1'b0, 1'b0, 2'h1);
      wr(AF, 8'h00);
      rd(AF, 8'h00);
      for (int i = 0; i < 5; i++) begin
         pls(SP[i]);
         rd(AF, EX[i]);
      end
      wr(AF, 8'h1E);
      rd(AF, 8'h04);
      rst_to(1'b1, 1'b0, 2'h0);
      wr(AF, 8'h00);
      pls(4'hF);
      rd(AF, 8'h03);
      wr(AC, 8'h0B);
      rd(AC, 8'h0B);
      wr(AC, 8'h04);
      rd(AC, 8'h0C);
   endtask
   task s_l2;
      rst_to(1'b0, 1'b1, 2'h2);
      wr(AC, 8'h18);
      wr(AC, 8'h00);
      rd(AC, 8'h08);
      wr(AC, 8'h18);
      wr(AC, 8'h03);
      rd(AC, 8'h0B);
      wr(AC, 8'h06);
      rd(AC, 8'h0B);
      stb <= 4'hE;
      wr(AC, 8'h18);
      wr(AC, 8'h05);
      stb <= 4'hF;
      rd(AC, 8'h0B);
      wr(12'h08C, 8'hFF);
      ck(e, 1'b1);
      rd(12'h08C, 8'h00);
      ck(e, 1'b1);
   endtask
   initial begin
      s_lvl();
      s_l1();
      s_tmo();
      s_flg();
      s_l2();
      final_report();
   end
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
endmodule // tb
`default_nettype wire
